// File: src/bfd_map.vh
// Register map, field positions, reset values and timing constants.
`ifndef BFD_MAP_VH
`define BFD_MAP_VH

// Register word offsets within one instance bank.
`define BFD_OFF_CTRL 3'h0
`define BFD_OFF_VPKP 3'h1
`define BFD_OFF_DPKP 3'h2
`define BFD_OFF_IPKP 3'h3
`define BFD_OFF_DLY 3'h4
// Address distance between the two instance banks.
`define BFD_INST_STRIDE 8
// Shared registers.
`define BFD_ADDR_STAT 8'h10
`define BFD_ADDR_MASK 8'h11
`define BFD_ADDR_LIVE 8'h12

// Control register fields.
`define BFD_CTRL_EN 0
`define BFD_CTRL_DUAL 1
`define BFD_CTRL_USE_STAT 2
`define BFD_CTRL_DELTA 3
`define BFD_CTRL_W 4

// Reset values.
`define BFD_CTRL_RST 4'h0
`define BFD_PKP_RST 16'hFFFF
`define BFD_DLY_RST 16'h0000
`define BFD_MASK_RST 4'h0

// Status bit layout: pickup events in bits 1:0, operate events in 3:2.
`define BFD_STAT_OP_LSB 2
`define BFD_STAT_W 4

// Timing: clock rate, millisecond length, supervision hold in power cycles.
`define BFD_CLK_MHZ 100
`define BFD_US_PER_MS 1000
`define BFD_SPV_CYCLES 6
`define BFD_SYS_CYCLE_MS 17

`endif

// File: src/bfd_top.v
// Two-instance per-phase breaker flashover detector with register port.
`timescale 1ns/1ns
`include "bfd_map.vh"

// Operation
// - Without a second source, arm only on recovered voltage, open status, no current.
// - Single-set mode ignores the across-breaker voltage difference for open detection.
// - Single-set flashover: status open, voltage below pickup, current above pickup.
// - Detection clears on zero current, breaker closing, or supervision high.
// - Without voltage present beforehand the element stays unarmed.
// - Dual-set arming: difference above pickup, voltage above pickup, no current.
// - Dual-set pickup: both voltages and difference low with current; timer starts.
// - Dual-set status input is optional but used for stability when enabled.
// - Only phase-to-ground voltages; delta connection never asserts flashover.
// - Each pole has its own status operand, evaluated separately.
// - Ready once voltage on either side exceeds the voltage pickup; single-set mode looks at side one only.
// - Per-phase supervision gating, held six power cycles after release.
// - Operate asserts only after pickup persists for the configured delay.
// - Current above the current pickup counts as flashover current.
// - Two identical instances, each with its own settings and inputs.
module bfd_top #(
  parameter W = 16,
  parameter MS_DIV = `BFD_CLK_MHZ * `BFD_US_PER_MS,
  parameter SYS_CYCLE_MS = `BFD_SYS_CYCLE_MS
) (
  // Clock and reset.
  input wire clk,
  input wire rstn,
  // Register port.
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_q,
  // Measurements, instance*3+phase, W bits each.
  input wire [6*W-1:0] side_one_volt,
  input wire [6*W-1:0] side_two_volt,
  input wire [6*W-1:0] phase_curr,
  // Operands, bit instance*3+phase, status high means pole closed.
  input wire [5:0] pole_status_operand,
  input wire [5:0] phase_supervision_operand,
  // Results.
  output reg [5:0] phase_pickup_q,
  output reg [1:0] pickup_q,
  output reg [1:0] operate_q,
  output reg irq_q
);

  localparam NI = 2;
  localparam NP = 6;
  localparam [31:0] SPV_HOLD_MS = `BFD_SPV_CYCLES * SYS_CYCLE_MS;

  // Extracts the W-bit measurement of one phase slot.
  function [W-1:0] slot;
    input [6*W-1:0] bus;
    input integer k;
    begin
      slot = bus[k*W +: W];
    end
  endfunction

  // Magnitude of the per-phase voltage difference across the breaker.
  function [W-1:0] absdiff;
    input [W-1:0] a;
    input [W-1:0] b;
    begin
      absdiff = (a > b) ? (a - b) : (b - a);
    end
  endfunction

  // True when the address hits register off of instance i.
  function hit;
    input [7:0] addr;
    input integer i;
    input [2:0] off;
    integer a;
    begin
      a = addr;
      hit = (a == i * `BFD_INST_STRIDE + off);
    end
  endfunction

  // Settings registers.
  reg [`BFD_CTRL_W-1:0] ctrl_q [0:NI-1];
  reg [W-1:0] vpkp_q [0:NI-1];
  reg [W-1:0] dpkp_q [0:NI-1];
  reg [W-1:0] ipkp_q [0:NI-1];
  reg [15:0] dly_q [0:NI-1];
  reg [`BFD_STAT_W-1:0] stat_q;
  reg [`BFD_STAT_W-1:0] mask_q;

  // Scheme state.
  reg [5:0] armed_q;
  reg [5:0] detect_q;
  reg [31:0] hold_q [0:NP-1];
  reg [15:0] tmr_q [0:NI-1];
  reg [31:0] div_q;
  reg ms_tick_q;
  reg [1:0] pickup_d;
  reg [1:0] operate_d;
  reg [`BFD_STAT_W-1:0] events;

  // Per-phase combinational terms.
  reg [5:0] blocked;
  reg [5:0] arm_cond;
  reg [5:0] fault_cond;
  reg [5:0] clear_cond;

  // Loop indices, one per process so that no index has two drivers.
  integer k;
  integer i;
  integer kh;
  integer ka;
  integer it;
  integer iw;
  integer ir;

  // Millisecond enable pulse for the timers.
  // The divider runs free, so a timer started mid-count may see its
  // first tick anywhere from one clock to a full period later.
  always @(posedge clk) begin
    if (!rstn) begin
      div_q <= 32'h00000000;
      ms_tick_q <= 1'b0;
    end else if (div_q >= MS_DIV - 1) begin
      div_q <= 32'h00000000;
      ms_tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 32'h00000001;
      ms_tick_q <= 1'b0;
    end
  end

  // Supervision hold: reloaded while the operand is high, counts down after.
  // The count is in millisecond ticks, so the hold lasts six power cycles
  // give or take one tick of the free-running divider.
  always @(posedge clk) begin
    for (kh = 0; kh < NP; kh = kh + 1) begin
      if (!rstn) begin
        hold_q[kh] <= 32'h00000000;
      end else if (phase_supervision_operand[kh]) begin
        hold_q[kh] <= SPV_HOLD_MS;
      end else if (ms_tick_q && hold_q[kh] != 32'h00000000) begin
        hold_q[kh] <= hold_q[kh] - 32'h00000001;
      end
    end
  end

  // Arming, fault and clearing conditions per phase.
  // All comparisons are strict, so a level equal to its pickup neither
  // arms nor faults; the clear term treats such current as zero.
  always @* begin
    for (k = 0; k < NP; k = k + 1) begin : cond
      reg [W-1:0] v1;
      reg [W-1:0] v2;
      reg [W-1:0] cur;
      reg [W-1:0] dv;
      reg dual;
      reg open_ok;
      reg cur_hi;
      reg [`BFD_CTRL_W-1:0] c;
      reg [W-1:0] vp;
      reg [W-1:0] dp;
      reg [W-1:0] ip;
      v1 = slot(side_one_volt, k);
      v2 = slot(side_two_volt, k);
      cur = slot(phase_curr, k);
      dv = absdiff(v1, v2);
      c = ctrl_q[k/3];
      vp = vpkp_q[k/3];
      dp = dpkp_q[k/3];
      ip = ipkp_q[k/3];
      dual = c[`BFD_CTRL_DUAL];
      cur_hi = (cur > ip);
      // Pole status is always used alone, optional with two sets.
      open_ok = !pole_status_operand[k];
      if (dual && !c[`BFD_CTRL_USE_STAT]) begin
        open_ok = 1'b1;
      end
      // Supervision and delta connection block the phase outright.
      blocked[k] = phase_supervision_operand[k] ||
                   (hold_q[k] != 32'h00000000) ||
                   c[`BFD_CTRL_DELTA] ||
                   !c[`BFD_CTRL_EN];
      if (dual) begin
        // Either live side makes the phase ready.
        arm_cond[k] = (dv > dp) && ((v1 > vp) || (v2 > vp)) &&
                      !cur_hi && open_ok;
        fault_cond[k] = (v1 < vp) && (v2 < vp) && (dv < dp) &&
                        cur_hi && open_ok;
      end else begin
        // Difference plays no part with one voltage set.
        arm_cond[k] = (v1 > vp) && open_ok && !cur_hi;
        fault_cond[k] = open_ok && (v1 < vp) && cur_hi;
      end
      clear_cond[k] = !cur_hi || pole_status_operand[k] || blocked[k];
    end
  end

  // Arm and detection latches per phase.
  // Detection never sets in a cycle whose clear terms hold, so a pole that
  // closes or a supervision operand that rises wins over a fresh fault.
  // Arming is dropped once detected, so a new event needs a fresh arm.
  always @(posedge clk) begin
    if (!rstn) begin
      armed_q <= 6'h00;
      detect_q <= 6'h00;
    end else begin
      for (ka = 0; ka < NP; ka = ka + 1) begin
        if (blocked[ka] || pole_status_operand[ka]) begin
          armed_q[ka] <= 1'b0;
        end else if (arm_cond[ka]) begin
          armed_q[ka] <= 1'b1;
        end else if (detect_q[ka]) begin
          armed_q[ka] <= 1'b0;
        end
        if (detect_q[ka] && clear_cond[ka]) begin
          detect_q[ka] <= 1'b0;
        end else if (armed_q[ka] && fault_cond[ka] && !clear_cond[ka]) begin
          detect_q[ka] <= 1'b1;
        end
      end
    end
  end

  // Pickup and operate of each instance.
  // Operate also needs the registered pickup, so even with zero delay it
  // follows pickup by one cycle.
  always @* begin
    for (i = 0; i < NI; i = i + 1) begin
      pickup_d[i] = |detect_q[i*3 +: 3];
      operate_d[i] = pickup_d[i] && pickup_q[i] &&
                     (tmr_q[i] >= dly_q[i]);
    end
  end

  // Pickup delay timers in milliseconds.
  // Any dropout of pickup puts the count back to zero, and the count stops
  // at its top value instead of wrapping to a false short delay.
  always @(posedge clk) begin
    for (it = 0; it < NI; it = it + 1) begin
      if (!rstn || !pickup_d[it]) begin
        tmr_q[it] <= 16'h0000;
      end else if (ms_tick_q && tmr_q[it] != 16'hFFFF) begin
        tmr_q[it] <= tmr_q[it] + 16'h0001;
      end
    end
  end

  // Output flops.
  // Every result leaves through a flop so that the far side never sees a
  // glitch from the comparators.
  always @(posedge clk) begin
    if (!rstn) begin
      phase_pickup_q <= 6'h00;
      pickup_q <= 2'h0;
      operate_q <= 2'h0;
    end else begin
      phase_pickup_q <= detect_q;
      pickup_q <= pickup_d;
      operate_q <= operate_d;
    end
  end

  // Rising edges of pickup and operate are the interrupt events.
  // Edges are taken against the output flops so that each event is seen
  // exactly once.
  always @* begin
    events = {operate_d & ~operate_q, pickup_d & ~pickup_q};
  end

  // Settings writes, one bank per instance.
  // Unmapped addresses match no bank and are ignored, and the pickups
  // reset to full scale so that nothing arms before software sets them.
  always @(posedge clk) begin
    for (iw = 0; iw < NI; iw = iw + 1) begin
      if (!rstn) begin
        ctrl_q[iw] <= `BFD_CTRL_RST;
        vpkp_q[iw] <= `BFD_PKP_RST;
        dpkp_q[iw] <= `BFD_PKP_RST;
        ipkp_q[iw] <= `BFD_PKP_RST;
        dly_q[iw] <= `BFD_DLY_RST;
      end else if (reg_wr) begin
        if (hit(reg_addr, iw, `BFD_OFF_CTRL)) begin
          ctrl_q[iw] <= reg_wdata[`BFD_CTRL_W-1:0];
        end
        if (hit(reg_addr, iw, `BFD_OFF_VPKP)) begin
          vpkp_q[iw] <= reg_wdata[W-1:0];
        end
        if (hit(reg_addr, iw, `BFD_OFF_DPKP)) begin
          dpkp_q[iw] <= reg_wdata[W-1:0];
        end
        if (hit(reg_addr, iw, `BFD_OFF_IPKP)) begin
          ipkp_q[iw] <= reg_wdata[W-1:0];
        end
        if (hit(reg_addr, iw, `BFD_OFF_DLY)) begin
          dly_q[iw] <= reg_wdata[15:0];
        end
      end
    end
  end

  // Mask register and sticky status; a new event wins over read-clear.
  // Letting the event win means an edge that lands on the read cycle is
  // kept for the next read instead of being lost.
  always @(posedge clk) begin
    if (!rstn) begin
      mask_q <= `BFD_MASK_RST;
      stat_q <= 4'h0;
    end else begin
      if (reg_wr && reg_addr == `BFD_ADDR_MASK) begin
        mask_q <= reg_wdata[`BFD_STAT_W-1:0];
      end
      if (reg_rd && reg_addr == `BFD_ADDR_STAT) begin
        stat_q <= events;
      end else begin
        stat_q <= stat_q | events;
      end
    end
  end

  // Level interrupt while any unmasked status bit is set.
  // It follows the status register's next value, so it rises and falls in
  // the same cycle as the bits that it reflects.
  always @(posedge clk) begin
    if (!rstn) begin
      irq_q <= 1'b0;
    end else if (reg_rd && reg_addr == `BFD_ADDR_STAT) begin
      irq_q <= |(events & mask_q);
    end else begin
      irq_q <= |((stat_q | events) & mask_q);
    end
  end

  // Read data, valid in the cycle after the read strobe.
  // Unmapped addresses and unused upper bits read as zero, since the word
  // is cleared before the matching register is laid over it.
  always @(posedge clk) begin
    if (!rstn) begin
      reg_rdata_q <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata_q <= 32'h00000000;
      for (ir = 0; ir < NI; ir = ir + 1) begin
        if (hit(reg_addr, ir, `BFD_OFF_CTRL)) begin
          reg_rdata_q[`BFD_CTRL_W-1:0] <= ctrl_q[ir];
        end
        if (hit(reg_addr, ir, `BFD_OFF_VPKP)) begin
          reg_rdata_q[W-1:0] <= vpkp_q[ir];
        end
        if (hit(reg_addr, ir, `BFD_OFF_DPKP)) begin
          reg_rdata_q[W-1:0] <= dpkp_q[ir];
        end
        if (hit(reg_addr, ir, `BFD_OFF_IPKP)) begin
          reg_rdata_q[W-1:0] <= ipkp_q[ir];
        end
        if (hit(reg_addr, ir, `BFD_OFF_DLY)) begin
          reg_rdata_q[15:0] <= dly_q[ir];
        end
      end
      if (reg_addr == `BFD_ADDR_STAT) begin
        reg_rdata_q[`BFD_STAT_W-1:0] <= stat_q;
      end
      if (reg_addr == `BFD_ADDR_MASK) begin
        reg_rdata_q[`BFD_STAT_W-1:0] <= mask_q;
      end
      if (reg_addr == `BFD_ADDR_LIVE) begin
        reg_rdata_q[15:0] <= {operate_q, pickup_q, detect_q, armed_q};
      end
    end
  end

endmodule // bfd_top

// File: verif/bfd_sva.sv
// Port checker for the flashover detector.
`timescale 1ns/1ns
module bfd_chk #(
  parameter W = 16
) (
  // Clock and reset.
  input wire clk,
  input wire rstn,
  // Register port.
  input wire [7:0] reg_addr,
  input wire reg_rd,
  input wire [31:0] reg_rdata_q,
  // Inputs and results.
  input wire [6*W-1:0] phase_curr,
  input wire [5:0] pole_status_operand,
  input wire [5:0] phase_supervision_operand,
  input wire [5:0] phase_pickup_q,
  input wire [1:0] pickup_q,
  input wire [1:0] operate_q,
  input wire irq_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // A closed pole or supervision clears detect two cycles on.
  property p_stat;
    (phase_pickup_q & $past(pole_status_operand, 2)) == 6'h00;
  endproperty
  a_stat: assert property (p_stat)
    else $error("detect on closed pole");
  property p_spv;
    (phase_pickup_q & $past(phase_supervision_operand, 2)) == 6'h00;
  endproperty
  a_spv: assert property (p_spv)
    else $error("detect while supervised");
  property p_hold;
    $fell(phase_supervision_operand[0]) |-> ##1 (!phase_pickup_q[0]) [*8];
  endproperty
  a_hold: assert property (p_hold)
    else $error("detect during hold");
  property p_cur;
    !(|phase_curr[W-1:0]) |-> ##2 !phase_pickup_q[0];
  endproperty
  a_cur: assert property (p_cur)
    else $error("detect without current");
  // Instance results follow the phase detects.
  property p_or;
    pickup_q == {|phase_pickup_q[5:3], |phase_pickup_q[2:0]};
  endproperty
  a_or: assert property (p_or)
    else $error("pickup not phase or");
  property p_op;
    (operate_q & ~$past(pickup_q)) == 2'h0;
  endproperty
  a_op: assert property (p_op)
    else $error("operate without pickup");
  // Read data carry only defined bits.
  property p_rdhi;
    $past(reg_rd) |-> reg_rdata_q[31:16] == 16'h0000;
  endproperty
  a_rdhi: assert property (p_rdhi)
    else $error("read upper bits set");
  property p_unmap;
    reg_rd && reg_addr == 8'h13 |=> reg_rdata_q == 32'h0000_0000;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  // Main scenarios reached.
  c_pk: cover property (pickup_q[0]);
  c_op: cover property (operate_q[1]);
  c_irq: cover property (irq_q);
endmodule // bfd_chk

// File: verif/bfd_src_model.sv
// Behavioural model of the measurement sources and pole contacts.
`timescale 1ns/1ns
module bfd_src_model #(
  parameter W = 16
) (
  // Clock and load request.
  input wire clk,
  input wire ld,
  input wire [3*W+3:0] cmd,
  // Measurements and pole status toward the detector.
  output reg [6*W-1:0] side_one_volt,
  output reg [6*W-1:0] side_two_volt,
  output reg [6*W-1:0] phase_curr,
  output reg [5:0] pole_status_operand
);
  // Command fields: slot, closed, side one, side two, current.
  wire [2:0] slot = cmd[3*W+3:3*W+1];
  // All slots start dead, open and without current.
  initial begin
    side_one_volt = {6*W{1'b0}};
    side_two_volt = {6*W{1'b0}};
    phase_curr = {6*W{1'b0}};
    pole_status_operand = 6'h00;
  end
  // A load changes one slot at the edge, like a fresh sample.
  always @(posedge clk) begin
    if (ld) begin
      pole_status_operand[slot] <= cmd[3*W];
      side_one_volt[slot*W +: W] <= cmd[3*W-1:2*W];
      side_two_volt[slot*W +: W] <= cmd[2*W-1:W];
      phase_curr[slot*W +: W] <= cmd[W-1:0];
    end
  end
endmodule // bfd_src_model

// File: verif/bfd_tb.sv
// Self-checking bench for the flashover detector.
`timescale 1ns/1ns
module testbench;
  // Bench-driven inputs.
  reg clk = 1'b0;
  reg rstn = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [5:0] phase_supervision_operand = 6'h00;
  reg ld = 1'b0;
  reg [51:0] cmd = 52'h0;
  // Outputs and bookkeeping.
  wire [31:0] reg_rdata_q;
  wire [95:0] side_one_volt;
  wire [95:0] side_two_volt;
  wire [95:0] phase_curr;
  wire [5:0] pole_status_operand;
  wire [5:0] phase_pickup_q;
  wire [1:0] pickup_q;
  wire [1:0] operate_q;
  wire irq_q;
  integer n_mismatch = 0;
  integer total_checks = 0;
  integer cyc = 0;
  reg [31:0] rd_q;
  // Clock of 10 ns.
  always #5 clk = ~clk;
  // Source model and the detector with short timing counts.
  bfd_src_model #(.W(16)) u_src (.clk, .ld, .cmd, .side_one_volt,
    .side_two_volt, .phase_curr, .pole_status_operand);
  bfd_top #(.W(16), .MS_DIV(10), .SYS_CYCLE_MS(1)) uut (.clk, .rstn,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
    .side_one_volt, .side_two_volt, .phase_curr, .pole_status_operand,
    .phase_supervision_operand, .phase_pickup_q, .pickup_q, .operate_q,
    .irq_q);
  // Compare and count.
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // Report and stop.
  task conclude;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // Hang guard.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch = n_mismatch + 1;
      conclude;
    end
  end
  // Register write, then one idle edge.
  task wr(input [7:0] a, input [31:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
    end
  endtask
  // Register read; data stand in the cycle after the strobe.
  task rd(input [7:0] a);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      rd_q = reg_rdata_q;
    end
  endtask
  // Load one slot of the source model.
  task meas(input [2:0] s, input k, input [15:0] a, input [15:0] b,
    input [15:0] c);
    begin
      cmd <= {s, k, a, b, c};
      ld <= 1'b1;
      @(posedge clk);
      ld <= 1'b0;
      @(posedge clk);
    end
  endtask
  // Bounded wait for pickup or operate of one instance.
  task wt(input integer i, input op);
    integer n;
    begin
      n = 0;
      while ((op ? operate_q[i] : pickup_q[i]) !== 1'b1 && n < 40) begin
        n = n + 1;
        @(posedge clk);
      end
    end
  endtask
  // Setting reset values and an unmapped place.
  task t_regs;
    begin
      rd(8'h01);
      chk(rd_q, 32'hFFFF);
      rd(8'h0C);
      chk(rd_q, 32'h0);
      wr(8'h13, 32'h5);
      rd(8'h13);
      chk(rd_q, 32'h0);
    end
  endtask
  // Single-set flashover, interrupt, supervision clear and hold.
  task t_single;
    begin
      wr(8'h01, 32'h1000);
      wr(8'h03, 32'h0100);
      wr(8'h11, 32'h1);
      wr(8'h00, 32'h1);
      meas(3'h0, 1'b0, 16'h2000, 16'h0, 16'h0);
      meas(3'h0, 1'b0, 16'h0800, 16'h0, 16'h0400);
      wt(0, 1'b0);
      chk(phase_pickup_q, 32'h1);
      @(posedge clk);
      chk(irq_q, 1'b1);
      chk(operate_q, 32'h1);
      rd(8'h10);
      chk(rd_q, 32'h5);
      @(posedge clk);
      chk(irq_q, 1'b0);
      phase_supervision_operand <= 6'h01;
      repeat (3) @(posedge clk);
      chk(phase_pickup_q, 32'h0);
      phase_supervision_operand <= 6'h00;
      meas(3'h0, 1'b0, 16'h2000, 16'h0, 16'h0);
      meas(3'h0, 1'b0, 16'h0800, 16'h0, 16'h0400);
      repeat (3) @(posedge clk);
      chk(phase_pickup_q, 32'h0);
    end
  endtask
  // Dead phase never arms; a closed pole never detects.
  task t_noarm;
    begin
      meas(3'h1, 1'b0, 16'h0800, 16'h0, 16'h0400);
      meas(3'h2, 1'b1, 16'h2000, 16'h0, 16'h0);
      meas(3'h2, 1'b1, 16'h0800, 16'h0, 16'h0400);
      repeat (4) @(posedge clk);
      chk(phase_pickup_q, 32'h0);
    end
  endtask
  // Delta connection blocks the element.
  task t_delta;
    begin
      wr(8'h00, 32'h9);
      meas(3'h2, 1'b0, 16'h2000, 16'h0, 16'h0);
      meas(3'h2, 1'b0, 16'h0800, 16'h0, 16'h0400);
      repeat (4) @(posedge clk);
      chk(pickup_q, 32'h0);
    end
  endtask
  // Dual-set flashover on the second instance, masked interrupt.
  task t_dual;
    begin
      wr(8'h09, 32'h1000);
      wr(8'h0A, 32'h0800);
      wr(8'h0B, 32'h0100);
      wr(8'h0C, 32'h2);
      wr(8'h08, 32'h3);
      meas(3'h3, 1'b0, 16'h2000, 16'h0, 16'h0);
      meas(3'h3, 1'b0, 16'h0800, 16'h0700, 16'h0400);
      wt(1, 1'b0);
      chk(phase_pickup_q, 32'h8);
      chk(operate_q, 32'h0);
      wt(1, 1'b1);
      chk(operate_q, 32'h2);
      chk(irq_q, 1'b0);
      rd(8'h10);
      chk(rd_q, 32'hA);
      // Current drop clears; a fresh pickup restarts the delay from zero.
      meas(3'h3, 1'b0, 16'h0800, 16'h0700, 16'h0000);
      repeat (2) @(posedge clk);
      chk(pickup_q, 32'h0);
      wr(8'h08, 32'h7);
      meas(3'h3, 1'b0, 16'h2000, 16'h0, 16'h0);
      meas(3'h3, 1'b0, 16'h0800, 16'h0700, 16'h0400);
      wt(1, 1'b0);
      repeat (3) @(posedge clk);
      chk(operate_q, 32'h0);
      wt(1, 1'b1);
      chk(operate_q, 32'h2);
      rd(8'h12);
      chk(rd_q, 32'hA200);
    end
  endtask
  // Main sequence.
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (80) @(posedge clk);
    t_regs;
    t_single;
    t_noarm;
    t_delta;
    t_dual;
    conclude;
  end
endmodule // testbench

bind bfd_top bfd_chk #(.W(W)) u_chk (.clk, .rstn, .reg_addr, .reg_rd,
  .reg_rdata_q, .phase_curr, .pole_status_operand,
  .phase_supervision_operand, .phase_pickup_q, .pickup_q, .operate_q,
  .irq_q);
